// File: hw/scb_pkg.sv
// Purpose: constants and carrier types of the synth control word bank
// Assumes: words arrive already shifted in and latched, one per strobe
// Notes:   bit positions are within the 32-bit loaded word
package scb_pkg;

  // ****************************************************************
  // register address codes (bits 3:0 of each word)
  // ****************************************************************
  localparam logic [3:0] ADDR_FREQ  = 4'h0;
  localparam logic [3:0] ADDR_CTRL  = 4'h4;
  localparam logic [3:0] ADDR_FIX5  = 4'h5;
  localparam logic [3:0] ADDR_OUT   = 4'h6;
  localparam logic [3:0] ADDR_LOCK  = 4'h7;
  localparam logic [3:0] ADDR_FIX8  = 4'h8;
  localparam logic [3:0] ADDR_BAND  = 4'h9;

  // ****************************************************************
  // field positions
  // ****************************************************************
  // reference/control word
  localparam int CTL_DBUF     = 14;
  localparam int CTL_PWRDN    = 6;
  localparam int CTL_TRISTATE = 5;
  localparam int CTL_CNTRST   = 4;
  // output path word
  localparam int OUT_GATED    = 30;
  localparam int OUT_NEGBLEED = 29;
  localparam int OUT_FBSEL    = 24;
  localparam int OUT_DIV_HI   = 23;
  localparam int OUT_DIV_LO   = 21;
  localparam int OUT_BLEED_HI = 20;
  localparam int OUT_BLEED_LO = 13;
  localparam int OUT_MUTE     = 11;
  localparam int OUT_AUX_EN   = 9;
  localparam int OUT_AUX_P_HI = 8;
  localparam int OUT_AUX_P_LO = 7;
  localparam int OUT_PRI_EN   = 6;
  localparam int OUT_PRI_P_HI = 5;
  localparam int OUT_PRI_P_LO = 4;
  // lock detect word
  localparam int LCK_LESYNC   = 25;
  localparam int LCK_CNT_HI   = 9;
  localparam int LCK_CNT_LO   = 8;
  localparam int LCK_LOSS     = 7;
  localparam int LCK_PREC_HI  = 6;
  localparam int LCK_PREC_LO  = 5;
  localparam int LCK_MODE     = 4;
  // band timing word
  localparam int BND_DIV_HI   = 31;
  localparam int BND_DIV_LO   = 24;
  localparam int BND_TO_HI    = 23;
  localparam int BND_TO_LO    = 14;

  // ****************************************************************
  // fixed words, reset values, lock windows in tenths of a ns
  // ****************************************************************
  localparam logic [31:0] FIX5_WORD  = 32'h0080_0005;
  localparam logic [31:0] FIX8_WORD  = 32'h1a69_a6b8;
  localparam logic [31:0] WORD_RST   = 32'h0000_0000;
  localparam logic [2:0]  DIV_RST    = 3'h0;
  localparam logic [7:0]  WIN_5_0    = 8'h32;
  localparam logic [7:0]  WIN_6_0    = 8'h3c;
  localparam logic [7:0]  WIN_8_0    = 8'h50;
  localparam logic [7:0]  WIN_12_0   = 8'h78;
  localparam logic [7:0]  WIN_INT    = 8'h1d;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic        valid;
    logic [31:0] word;
  } scb_load_t;

  typedef struct packed {
    logic       primary_en;
    logic [1:0] primary_power;
    logic       aux_en;
    logic [1:0] aux_power;
  } scb_stage_t;

  typedef enum logic {
    LD_IDLE = 1'b0,
    LD_WAIT = 1'b1
  } scb_ld_state_t;

endpackage

// File: hw/scb_bank.sv
// Purpose: control word bank of a fractional-N synthesizer
// Assumes: load_in comes from the serial latch logic on clk_in
// Notes:   config outputs follow a stored word by two clock edges
//
// Summary of operation
// - power-down bit 6 stops the synth; clearing it resumes; contents kept
// - power-down: counters load, oscillator off, pump tristated, outputs off
// - pump tristate bit 5 puts charge pump output in high impedance
// - counter reset bit 4 holds both counters and band select in reset
// - address codes 0110, 0111, 1001 route to output, lock, band registers
// - gated bleed bit 30 keeps bleed off until lock is reported
// - bit 29 enables constant negative bleed; host uses it only fractionally
// - feedback select bit 24 picks undivided oscillator or divider output
// - divider select 23:21 waits for register 0 when double buffered
// - mute bit 11 keeps output supply off until lock
// - bit 9 enables auxiliary output; bits 8:7 set its power
// - bit 6 enables primary output; bits 5:4 set its power
// - load-enable sync bit 25 delays counter load to next reference rise
// - count field 9:8 sets in-window cycles needed before lock
// - bit 7 enables loss-of-lock mode; host avoids it with differential ref
// - precision 6:5 selects 5, 6, 8 or 12 ns window
// - mode bit picks programmed window when 0, fixed 2.9 ns when 1
// - band register holds 8-bit divider 31:24 and 10-bit timeout 23:14
// - double buffer bit 14 decides if divider waits for register 0
// - frequency changes and buffered settings apply only on register 0
module scb_bank
  import scb_pkg::*;
(
  // clock and reset
  input  wire logic                clk_in,
  input  wire logic                reset_n_in,
  // latched serial words
  input  wire scb_pkg::scb_load_t  load_in,
  // analog-side pins, asynchronous
  input  wire logic                lock_detect_in,
  input  wire logic                ref_clk_in,
  // power and pump control
  output logic                     powerdown_out,
  output logic                     osc_powerdown_out,
  output logic                     pump_tristate_out,
  output logic                     counters_reset_out,
  output logic                     counters_load_state_out,
  output logic                     lock_detect_reset_out,
  output logic                     counter_load_out,
  // output stages and bleed
  output scb_pkg::scb_stage_t      stage_out,
  output logic                     bleed_on_out,
  output logic                     negative_bleed_out,
  output logic [7:0]               bleed_level_out,
  output logic                     feedback_direct_out,
  output logic [2:0]               out_divider_out,
  // lock detect and band search
  output logic [1:0]               lock_count_out,
  output logic                     loss_of_lock_mode_out,
  output logic [7:0]               lock_window_tenths_out,
  output logic [7:0]               band_div_out,
  output logic [9:0]               band_timeout_out,
  output logic                     fixed_words_ok_out
);
  import scb_pkg::*;

  // every assertion below samples on the rising edge, quiet in reset
  default clocking a_chk_cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // ****************************************************************
  // window width decode
  // ****************************************************************
  function automatic logic [7:0] win_tenths(input logic [1:0] prec,
                                            input logic       fixed);
    logic [7:0] w;
    w = WIN_12_0;
    if (fixed) begin
      w = WIN_INT;
    end else begin
      unique case (prec)
        2'b00: w = WIN_5_0;
        2'b01: w = WIN_6_0;
        2'b10: w = WIN_8_0;
        2'b11: w = WIN_12_0;
      endcase
    end
    return w;
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic lock_m_r, lock_s_r, ref_m_r, ref_s_r, ref_d_r;
  logic ref_rise;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      lock_m_r <= 1'b0;
      lock_s_r <= 1'b0;
      ref_m_r  <= 1'b0;
      ref_s_r  <= 1'b0;
      ref_d_r  <= 1'b0;
    end else begin
      lock_m_r <= lock_detect_in;
      lock_s_r <= lock_m_r;
      ref_m_r  <= ref_clk_in;
      ref_s_r  <= ref_m_r;
      ref_d_r  <= ref_s_r;
    end
  end

  assign ref_rise = ref_s_r & ~ref_d_r;

  // ****************************************************************
  // register file
  // ****************************************************************
  logic [31:0] ctrl_r, out6_r, lock7_r, band9_r, fix5_r, fix8_r;
  logic [31:0] ctrl_nxt, out6_nxt, lock7_nxt, band9_nxt;
  logic [31:0] fix5_nxt, fix8_nxt;
  logic [2:0]  div_r, div_nxt;
  logic [3:0]  addr;
  logic        wr_freq;
  logic [2:0]  load_div;

  assign addr     = load_in.word[3:0];
  assign wr_freq  = load_in.valid && (addr == ADDR_FREQ);
  assign load_div = load_in.word[OUT_DIV_HI:OUT_DIV_LO];

  // decode; writes keep landing in power-down too
  always_comb begin
    ctrl_nxt  = ctrl_r;
    out6_nxt  = out6_r;
    lock7_nxt = lock7_r;
    band9_nxt = band9_r;
    fix5_nxt  = fix5_r;
    fix8_nxt  = fix8_r;
    div_nxt   = div_r;
    if (load_in.valid) begin
      unique case (addr)
        ADDR_CTRL: ctrl_nxt  = load_in.word;
        ADDR_FIX5: fix5_nxt  = load_in.word;
        ADDR_OUT:  out6_nxt  = load_in.word;
        ADDR_LOCK: lock7_nxt = load_in.word;
        ADDR_FIX8: fix8_nxt  = load_in.word;
        ADDR_BAND: band9_nxt = load_in.word;
        default:   ;
      endcase
    end
    // unbuffered divider follows its own write at once
    if (load_in.valid && addr == ADDR_OUT && !ctrl_r[CTL_DBUF]) begin
      div_nxt = load_div;
    end
    // buffered divider waits for the frequency word
    if (wr_freq) begin
      div_nxt = out6_r[OUT_DIV_HI:OUT_DIV_LO];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ctrl_r  <= WORD_RST;
      out6_r  <= WORD_RST;
      lock7_r <= WORD_RST;
      band9_r <= WORD_RST;
      fix5_r  <= WORD_RST;
      fix8_r  <= WORD_RST;
      div_r   <= DIV_RST;
    end else begin
      ctrl_r  <= ctrl_nxt;
      out6_r  <= out6_nxt;
      lock7_r <= lock7_nxt;
      band9_r <= band9_nxt;
      fix5_r  <= fix5_nxt;
      fix8_r  <= fix8_nxt;
      div_r   <= div_nxt;
    end
  end

  // ****************************************************************
  // counter load sequencing
  // ****************************************************************
  scb_ld_state_t ld_r, ld_nxt;
  logic          cload_nxt;

  // sync mode trades a few cycles of latency for a clean ref phase
  always_comb begin
    ld_nxt    = ld_r;
    cload_nxt = 1'b0;
    unique case (ld_r)
      LD_IDLE: begin
        if (wr_freq && lock7_r[LCK_LESYNC]) begin
          ld_nxt = LD_WAIT;
        end else if (wr_freq) begin
          cload_nxt = 1'b1;
        end
      end
      LD_WAIT: begin
        if (ref_rise) begin
          ld_nxt    = LD_IDLE;
          cload_nxt = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ld_r             <= LD_IDLE;
      counter_load_out <= 1'b0;
    end else begin
      ld_r             <= ld_nxt;
      counter_load_out <= cload_nxt;
    end
  end

  // ****************************************************************
  // registered control outputs
  // ****************************************************************
  logic       pd, locked;
  logic       pd_nxt, tri_nxt, crst_nxt, bleed_nxt;
  scb_stage_t stage_nxt;

  assign pd     = ctrl_r[CTL_PWRDN];
  assign locked = lock_s_r & ~pd;

  // output stages, bleed and pump derived from stored words
  always_comb begin
    pd_nxt   = pd;
    tri_nxt  = pd | ctrl_r[CTL_TRISTATE];
    crst_nxt = ctrl_r[CTL_CNTRST];
    // mute blocks both stages until lock is seen
    stage_nxt.primary_en = out6_r[OUT_PRI_EN] & ~pd
      & ~(out6_r[OUT_MUTE] & ~locked);
    stage_nxt.aux_en = out6_r[OUT_AUX_EN] & ~pd
      & ~(out6_r[OUT_MUTE] & ~locked);
    stage_nxt.primary_power = out6_r[OUT_PRI_P_HI:OUT_PRI_P_LO];
    stage_nxt.aux_power = out6_r[OUT_AUX_P_HI:OUT_AUX_P_LO];
    bleed_nxt = ~pd & ~(out6_r[OUT_GATED] & ~locked);
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      powerdown_out           <= 1'b0;
      osc_powerdown_out       <= 1'b0;
      pump_tristate_out       <= 1'b0;
      counters_reset_out      <= 1'b0;
      counters_load_state_out <= 1'b0;
      lock_detect_reset_out   <= 1'b0;
      stage_out               <= '0;
      bleed_on_out            <= 1'b0;
      negative_bleed_out      <= 1'b0;
      bleed_level_out         <= 8'h00;
      feedback_direct_out     <= 1'b0;
      out_divider_out         <= DIV_RST;
      lock_count_out          <= 2'h0;
      loss_of_lock_mode_out   <= 1'b0;
      lock_window_tenths_out  <= WIN_5_0;
      band_div_out            <= 8'h00;
      band_timeout_out        <= 10'h000;
      fixed_words_ok_out      <= 1'b0;
    end else begin
      powerdown_out           <= pd_nxt;
      osc_powerdown_out       <= pd_nxt;
      pump_tristate_out       <= tri_nxt;
      counters_reset_out      <= crst_nxt;
      counters_load_state_out <= pd_nxt;
      lock_detect_reset_out   <= pd_nxt;
      stage_out               <= stage_nxt;
      bleed_on_out            <= bleed_nxt;
      negative_bleed_out      <= out6_r[OUT_NEGBLEED];
      bleed_level_out         <= out6_r[OUT_BLEED_HI:OUT_BLEED_LO];
      feedback_direct_out     <= out6_r[OUT_FBSEL];
      out_divider_out         <= div_r;
      lock_count_out          <= lock7_r[LCK_CNT_HI:LCK_CNT_LO];
      loss_of_lock_mode_out   <= lock7_r[LCK_LOSS];
      lock_window_tenths_out  <= win_tenths(
        lock7_r[LCK_PREC_HI:LCK_PREC_LO], lock7_r[LCK_MODE]);
      band_div_out            <= band9_r[BND_DIV_HI:BND_DIV_LO];
      band_timeout_out        <= band9_r[BND_TO_HI:BND_TO_LO];
      fixed_words_ok_out      <= (fix5_r == FIX5_WORD)
                              && (fix8_r == FIX8_WORD);
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_pd_pump_off: assert property (
    pd |=> pump_tristate_out && !stage_out.primary_en)
    else $error("power-down left pump or output active");
  a_tristate_bit: assert property (
    ctrl_r[CTL_TRISTATE] |=> pump_tristate_out)
    else $error("pump not tristated");
  a_cnt_reset: assert property (
    (load_in.valid && addr == ADDR_CTRL) |-> ##2
    counters_reset_out == $past(load_in.word[CTL_CNTRST], 2))
    else $error("counter reset does not follow bit");
  a_route_six: assert property (
    (load_in.valid && addr == ADDR_OUT) |=> out6_r == $past(load_in.word))
    else $error("output word not stored");
  a_other_kept: assert property (
    (load_in.valid && addr != ADDR_BAND) |=> $stable(band9_r))
    else $error("band word changed by other address");
  a_div_immed: assert property (
    (load_in.valid && addr == ADDR_OUT && !ctrl_r[CTL_DBUF]) |=>
    div_r == $past(load_div))
    else $error("unbuffered divider not applied");
  a_div_held: assert property (
    (load_in.valid && addr == ADDR_OUT && ctrl_r[CTL_DBUF]) |=>
    $stable(div_r))
    else $error("buffered divider applied early");
  a_gated_bleed: assert property (
    (out6_r[OUT_GATED] && !lock_s_r) |=> !bleed_on_out)
    else $error("bleed on before lock");
  a_mute_lock: assert property (
    (out6_r[OUT_MUTE] && !lock_s_r) |=> !stage_out.aux_en)
    else $error("output powered before lock");
  a_load_now: assert property (
    (wr_freq && ld_r == LD_IDLE && !lock7_r[LCK_LESYNC])
    |=> counter_load_out)
    else $error("counter load missing");
  a_le_sync: assert property (
    (ld_r == LD_WAIT && !ref_rise) |=> !counter_load_out)
    else $error("load before reference rise");
  a_win_int: assert property (
    lock7_r[LCK_MODE] |=> lock_window_tenths_out == WIN_INT)
    else $error("integer window not selected");

endmodule

// File: verification/scb_host_model.sv
// Purpose: host side model that hands latched words to the bank
// Assumes: words change on the falling clock edge only
// Notes:   word lines show the inverse of the last word while idle
module scb_host_model
  import scb_pkg::*;
(
  // clock
  input  wire logic          clk_in,
  // latched words toward the bank
  output scb_pkg::scb_load_t load_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // word delivery
  // ****************************************************************
  // idle until the first word is sent
  initial load_out = '{valid: 1'b0, word: 32'h0000_0000};

  // one word per strobe, valid for one clock only
  task automatic send(input logic [31:0] w);
    @(negedge clk_in);
    load_out = '{valid: 1'b1, word: w};
    @(negedge clk_in);
    // stale word inverted so a late sample cannot pass by luck
    load_out = '{valid: 1'b0, word: ~w};
  endtask

  // fixed words, never altered by the host
  task automatic send_fixed();
    send(FIX5_WORD);
    send(FIX8_WORD);
  endtask

  // output word: reserved 28:25 as 1010, bits 31, 12 and 10 cleared
  task automatic send_out(input logic [31:0] w);
    send((w & 32'h61ff_ebf0) | 32'h1400_0006);
  endtask

  // band word: reserved 13:9 forced to ones
  task automatic send_band(input logic [31:0] w);
    send((w & 32'hffff_c1f0) | 32'h0000_3e09);
  endtask
endmodule

// File: verification/scb_bank_tb.sv
// Purpose: self-checking bench of the synth control word bank
// Assumes: inputs move on the falling edge; outputs settle in two edges
// Notes:   lock pin passes a two-stage synchronizer first
module scb_bank_tb
  import scb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // signals and instances
  // ****************************************************************
  logic        clk_in = 1'b0;
  logic        reset_n_in;
  logic        lock_in;
  logic        ref_in;
  scb_load_t   load;
  scb_stage_t  stage;
  logic        pd, osc_pd, pump_ts, cnt_rst, cnt_ld_st, ld_rst, cnt_load;
  logic        bleed_on, neg_bleed, fb_dir, loss_md, fixed_ok;
  logic [7:0]  bleed_lvl, win, band_div;
  logic [2:0]  out_div;
  logic [1:0]  lock_cnt;
  logic [9:0]  band_to;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  logic [31:0] base = 32'h210a_a350;

  // 100 MHz clock
  always #5 clk_in = ~clk_in;

  scb_host_model i_scb_host_model (.clk_in(clk_in), .load_out(load));

  scb_bank i_scb_bank (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .load_in(load),
    .lock_detect_in(lock_in), .ref_clk_in(ref_in),
    .powerdown_out(pd), .osc_powerdown_out(osc_pd),
    .pump_tristate_out(pump_ts), .counters_reset_out(cnt_rst),
    .counters_load_state_out(cnt_ld_st), .lock_detect_reset_out(ld_rst),
    .counter_load_out(cnt_load), .stage_out(stage),
    .bleed_on_out(bleed_on), .negative_bleed_out(neg_bleed),
    .bleed_level_out(bleed_lvl), .feedback_direct_out(fb_dir),
    .out_divider_out(out_div), .lock_count_out(lock_cnt),
    .loss_of_lock_mode_out(loss_md), .lock_window_tenths_out(win),
    .band_div_out(band_div), .band_timeout_out(band_to),
    .fixed_words_ok_out(fixed_ok));

  // ****************************************************************
  // shared helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // derived outputs trail the take edge by two edges
  task automatic settle();
    repeat (3) @(negedge clk_in);
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // hang guard, far above the 140 or so cycles the run needs
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    chk(32'({pd, pump_ts, cnt_rst, cnt_load, fixed_ok}), 32'h0);
    chk(32'(win), 32'(WIN_5_0));
    chk(32'(out_div), 32'(DIV_RST));
  endtask

  // output word fields, then gating by lock
  task automatic t_output();
    i_scb_host_model.send_out(base);
    settle();
    chk(32'(stage), 32'h2e);
    chk(32'({neg_bleed, fb_dir, bleed_on}), 32'h7);
    chk(32'(bleed_lvl), 32'h55);
    lock_in = 1'b0;
    i_scb_host_model.send_out(base | 32'h4000_0800);
    settle();
    chk(32'(stage), 32'h0a);
    chk(32'(bleed_on), 32'h0);
    lock_in = 1'b1;
    repeat (4) @(negedge clk_in);
    chk(32'({stage, bleed_on}), 32'h5d);
  endtask

  // every precision code, mode, count and loss-of-lock setting
  task automatic t_lock();
    logic [7:0] tbl [4] = '{WIN_5_0, WIN_6_0, WIN_8_0, WIN_12_0};
    for (int i = 0; i < 4; i++) begin
      i_scb_host_model.send(32'h1000_0007 | 32'(i << 5) | 32'(i << 8)
                            | 32'((i & 1) << 7));
      settle();
      chk(32'(win), 32'(tbl[i]));
      chk(32'({lock_cnt, loss_md}), 32'((i << 1) | (i & 1)));
    end
    i_scb_host_model.send(32'h1000_0017);
    settle();
    chk(32'(win), 32'(WIN_INT));
    chk(32'(loss_md), 32'h0);
  endtask

  task automatic t_band();
    i_scb_host_model.send_band({8'ha5, 10'h2c3, 14'h0});
    settle();
    chk(32'({band_div, band_to}), 32'({8'ha5, 10'h2c3}));
  endtask

  // unmapped codes leave every register alone; fixed words stored
  task automatic t_route();
    logic [3:0] bad [9] = '{1, 2, 3, 10, 11, 12, 13, 14, 15};
    foreach (bad[k]) i_scb_host_model.send(32'hffff_fff0 | 32'(bad[k]));
    settle();
    chk(32'({band_div, band_to}), 32'({8'ha5, 10'h2c3}));
    chk(32'({win, neg_bleed, fixed_ok}), {22'h0, WIN_INT, 2'h2});
    i_scb_host_model.send_fixed();
    settle();
    chk(32'(fixed_ok), 32'h1);
  endtask

  // divider select applies at once, or waits for the frequency word
  task automatic t_divider();
    i_scb_host_model.send(32'h0000_1007);
    i_scb_host_model.send(32'h0000_0004);
    i_scb_host_model.send_out(base | 32'h00a0_0000);
    settle();
    chk(32'(out_div), 32'h5);
    i_scb_host_model.send(32'h0000_4004);
    i_scb_host_model.send_out(base | 32'h0060_0000);
    i_scb_host_model.send_band({8'ha5, 10'h2c3, 14'h0});
    settle();
    chk(32'({out_div, cnt_load}), 32'ha);
    i_scb_host_model.send(32'h0000_0000);
    // load pulse stands only in the cycle right after the take edge
    chk(32'(cnt_load), 32'h1);
    @(negedge clk_in);
    chk(32'({out_div, cnt_load}), 32'h6);
  endtask

  // power-down keeps contents and still latches words
  task automatic t_power();
    i_scb_host_model.send(32'h0000_0044);
    settle();
    chk(32'({pd, osc_pd, pump_ts, cnt_ld_st, ld_rst}), 32'h1f);
    chk(32'({stage.primary_en, stage.aux_en, bleed_on}), 32'h0);
    i_scb_host_model.send_out(base & 32'hdfff_ffbf);
    i_scb_host_model.send(32'h0000_0004);
    settle();
    chk(32'({pd, pump_ts, cnt_ld_st, ld_rst}), 32'h0);
    chk(32'({stage, neg_bleed}), 32'h1c);
    i_scb_host_model.send(32'h0000_0024);
    settle();
    chk(32'({pd, pump_ts, cnt_rst}), 32'h2);
    i_scb_host_model.send(32'h0000_0014);
    settle();
    chk(32'({pump_ts, cnt_rst}), 32'h1);
  endtask

  // counter load waits for a reference rise when sync is on
  task automatic t_sync();
    int seen = 0;
    i_scb_host_model.send(32'h1200_0007);
    i_scb_host_model.send(32'h0000_0000);
    // an unknown load level counts as a pulse so it cannot slip through
    repeat (8) @(negedge clk_in) seen += int'(cnt_load !== 1'b0);
    chk(32'(seen), 32'h0);
    ref_in = 1'b1;
    repeat (8) @(negedge clk_in) seen += int'(cnt_load !== 1'b0);
    ref_in = 1'b0;
    chk(32'(seen), 32'h1);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    reset_n_in = 1'b0;
    lock_in    = 1'b1;
    ref_in     = 1'b0;
    repeat (4) @(negedge clk_in);
    reset_n_in = 1'b1;
    @(negedge clk_in);
    t_reset();
    t_output();
    t_lock();
    t_band();
    t_route();
    t_divider();
    t_power();
    t_sync();
    summarize();
  end
endmodule
